// [hw/snfe_pkg.sv]
// Constants and carrier types shared by the serial NAND front end.
package snfe_pkg;

  localparam int PAGE_MAIN      = 2048;
  localparam int PAGE_SPARE     = 64;
  localparam int PAGE_BYTES     = PAGE_MAIN + PAGE_SPARE;
  localparam int PAGES_PER_BLK  = 64;
  localparam int BLOCKS         = 4096;
  localparam int ECC_UNIT       = 528;
  localparam int OTP_BYTES      = 16384;
  localparam int UID_BITS       = 64;
  localparam int COL_W          = 12;
  localparam int PAGE_W         = $clog2(PAGES_PER_BLK);
  localparam int BLK_W          = $clog2(BLOCKS);
  localparam int ROW_W          = PAGE_W + BLK_W;

  localparam logic [COL_W-1:0] COL_LAST  = COL_W'(PAGE_BYTES - 1);
  localparam logic [COL_W-1:0] MASK_2048 = COL_W'(PAGE_MAIN - 1);
  localparam logic [COL_W-1:0] MASK_64   = 12'h03F;
  localparam logic [COL_W-1:0] MASK_16   = 12'h00F;
  localparam logic [COL_W-1:0] ECC_B1    = COL_W'(ECC_UNIT);
  localparam logic [COL_W-1:0] ECC_B2    = COL_W'(2 * ECC_UNIT);
  localparam logic [COL_W-1:0] ECC_B3    = COL_W'(3 * ECC_UNIT);
  localparam logic [ROW_W-1:0] OTP_PAGES = ROW_W'(OTP_BYTES / PAGE_MAIN);

  localparam logic [3:0] WRAP_2112 = 4'h0;
  localparam logic [3:0] WRAP_2048 = 4'h1;
  localparam logic [3:0] WRAP_64   = 4'h2;
  localparam logic [3:0] WRAP_16   = 4'h3;

  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;

  localparam logic [2:0] COL_ADDR_BYTES  = 3'h2;
  localparam logic [2:0] ROW_ADDR_BYTES  = 3'h3;
  localparam logic [2:0] DUMMY_BYTES     = 3'h1;
  localparam logic [2:0] UID_DUMMY_BYTES = 3'h4;
  localparam logic [7:0] FILL_BYTE       = 8'hFF;

  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_FREAD    = 8'h0B;
  localparam logic [7:0] OP_READ_X2  = 8'h3B;
  localparam logic [7:0] OP_READ_X4  = 8'h6B;
  localparam logic [7:0] OP_LOAD     = 8'h02;
  localparam logic [7:0] OP_LOAD_RND = 8'h84;
  localparam logic [7:0] OP_LOAD_X4  = 8'h32;
  localparam logic [7:0] OP_LRND_X4A = 8'hC4;
  localparam logic [7:0] OP_LRND_X4B = 8'h34;
  localparam logic [7:0] OP_READ_UID = 8'h4B;
  localparam logic [7:0] OP_PG_READ  = 8'h13;
  localparam logic [7:0] OP_PG_EXEC  = 8'h10;
  localparam logic [7:0] OP_ERASE    = 8'hD8;
  localparam logic [7:0] OP_LOCK     = 8'h36;
  localparam logic [7:0] OP_UNLOCK   = 8'h39;
  localparam logic [7:0] OP_RD_LOCK  = 8'h3D;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_CMD   = 3'b001,
    PH_ADDR  = 3'b010,
    PH_DUMMY = 3'b011,
    PH_DOUT  = 3'b100,
    PH_DIN   = 3'b101,
    PH_SKIP  = 3'b110
  } snfe_phase_t;

  typedef struct packed {
    logic [7:0]        opcode;
    logic [BLK_W-1:0]  block;
    logic [PAGE_W-1:0] page;
    logic [COL_W-1:0]  column;
    logic [1:0]        ecc_unit;
    logic              row_oob;
  } snfe_cmd_t;

  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic [3:0] io;
  } snfe_pin_in_t;

  typedef struct packed {
    logic [3:0] io;
    logic [3:0] oe;
  } snfe_pin_out_t;

  typedef struct packed {
    logic             we;
    logic [COL_W-1:0] addr;
    logic [7:0]       wdata;
  } snfe_mem_req_t;

endpackage : snfe_pkg

// [hw/snfe_buf2.sv]
// Two-entry valid/ready buffer between cache fetch and the output shifter.
`timescale 1ns/1ps
module snfe_buf2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         flush,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } snfe_buf_state_t;

  snfe_buf_state_t st;
  snfe_buf_state_t next_st;
  logic            push;
  logic            pop;

  assign in_ready  = st.cnt != CW'(DEPTH);
  assign out_valid = st.cnt != '0;
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (flush) begin
      next_st.wp  = '0;
      next_st.rp  = '0;
      next_st.cnt = '0;
    end else begin
      if (push) begin
        next_st.mem[st.wp] = in_data;
        next_st.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
      end
      if (pop) begin
        next_st.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
      end
      next_st.cnt = st.cnt + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : snfe_buf2

// [hw/snfe_cache.sv]
// One-page cache buffer with a serial-side port and an array-side port.
`timescale 1ns/1ps
module snfe_cache #(
  parameter int BYTES = snfe_pkg::PAGE_BYTES
) (
  input  wire logic                  core_clk,
  input  wire snfe_pkg::snfe_mem_req_t ser_req,
  output logic [7:0]                 ser_rdata,
  input  wire snfe_pkg::snfe_mem_req_t core_req,
  output logic [7:0]                 core_rdata
);
  import snfe_pkg::*;

  logic [7:0] mem [BYTES];

  // Holes above the last byte read as erased; the array side wins a same-byte clash.
  always_ff @(posedge core_clk) begin
    if (ser_req.we && ser_req.addr <= COL_LAST) begin
      mem[ser_req.addr] <= ser_req.wdata;
    end
    if (core_req.we && core_req.addr <= COL_LAST) begin
      mem[core_req.addr] <= core_req.wdata;
    end
    ser_rdata  <= (ser_req.addr <= COL_LAST) ? mem[ser_req.addr] : FILL_BYTE;
    core_rdata <= (core_req.addr <= COL_LAST) ? mem[core_req.addr] : FILL_BYTE;
  end
endmodule : snfe_cache

// [hw/snfe_top.sv]
// Serial front end: frames, shifts and steers the x1, x2 and x4 pins of the NAND.
`timescale 1ns/1ps
module snfe_top #(
  parameter logic [snfe_pkg::UID_BITS-1:0] UNIQUE_ID = 64'h1357_9BDF_2468_ACE0 // Arbitrary value.
) (
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  input  wire snfe_pkg::snfe_pin_in_t  pin_in,
  output snfe_pkg::snfe_pin_out_t      pin_out,
  input  wire logic                    quad_enable_bit,
  input  wire logic                    otp_mode,
  output logic                         cmd_valid,
  output snfe_pkg::snfe_cmd_t          cmd,
  output logic                         frame_active,
  output logic                         column_oob,
  input  wire snfe_pkg::snfe_mem_req_t core_req,
  output logic [7:0]                   core_rdata
);
  import snfe_pkg::*;

  typedef struct packed {
    logic             sck;
    logic             cs_n;
    snfe_phase_t      ph;
    logic [7:0]       op;
    logic [7:0]       sh;
    logic [2:0]       bits;
    logic [2:0]       nbytes;
    logic [23:0]      addr;
    logic [2:0]       lin;
    logic [2:0]       lout;
    logic [COL_W-1:0] col;
    logic [3:0]       wrap;
    logic             mw;
    logic [7:0]       mdata;
    logic             fpend;
    logic             uid;
    logic [2:0]       uidx;
    logic [7:0]       fbyte;
    logic [7:0]       osh;
    logic [2:0]       obits;
    logic [3:0]       io;
    logic [3:0]       oe;
    logic             oob;
    logic             cvalid;
    snfe_cmd_t        cmd;
  } snfe_state_t;

  function automatic logic is_read(input logic [7:0] o);
    is_read = (o == OP_READ) || (o == OP_FREAD) || (o == OP_READ_X2) || (o == OP_READ_X4);
  endfunction : is_read

  function automatic logic is_load(input logic [7:0] o);
    is_load = (o == OP_LOAD) || (o == OP_LOAD_RND) || (o == OP_LOAD_X4)
           || (o == OP_LRND_X4A) || (o == OP_LRND_X4B);
  endfunction : is_load

  function automatic logic is_quad(input logic [7:0] o);
    is_quad = (o == OP_READ_X4) || (o == OP_LOAD_X4) || (o == OP_LRND_X4A)
           || (o == OP_LRND_X4B);
  endfunction : is_quad

  function automatic logic is_row(input logic [7:0] o);
    is_row = (o == OP_PG_READ) || (o == OP_PG_EXEC) || (o == OP_ERASE)
          || (o == OP_LOCK) || (o == OP_UNLOCK) || (o == OP_RD_LOCK);
  endfunction : is_row

  // Bits enter at the bottom so the first bit on the wire ends up as bit 7.
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] d,
                                          input logic [2:0] l);
    case (l)
      LANES_4: shift_in = {s[3:0], d};
      LANES_2: shift_in = {s[5:0], d[1:0]};
      default: shift_in = {s[6:0], d[0]};
    endcase
  endfunction : shift_in

  function automatic logic [3:0] drive_bits(input logic [7:0] c, input logic [2:0] l);
    case (l)
      LANES_4: drive_bits = c[7:4];
      LANES_2: drive_bits = {2'h0, c[7:6]};
      default: drive_bits = {2'h0, c[7], 1'b0};
    endcase
  endfunction : drive_bits

  function automatic logic [3:0] lane_mask(input logic [2:0] l);
    case (l)
      LANES_4: lane_mask = 4'hF;
      LANES_2: lane_mask = 4'h3;
      default: lane_mask = 4'h2;
    endcase
  endfunction : lane_mask

  function automatic logic [COL_W-1:0] wrap_next(input logic [COL_W-1:0] c,
                                                 input logic [3:0] w);
    logic [COL_W-1:0] m;
    m = MASK_16;
    case (w)
      WRAP_2048: m = MASK_2048;
      WRAP_64:   m = MASK_64;
      WRAP_16:   m = MASK_16;
      default:   m = '0;
    endcase
    if (w != WRAP_2048 && w != WRAP_64 && w != WRAP_16) begin
      wrap_next = (c >= COL_LAST) ? '0 : c + 1'b1;
    end else begin
      wrap_next = ((c & m) == m) ? (c & ~m) : c + 1'b1;
    end
  endfunction : wrap_next

  function automatic logic [1:0] ecc_unit_of(input logic [COL_W-1:0] c);
    if (c < ECC_B1) ecc_unit_of = 2'h0;
    else if (c < ECC_B2) ecc_unit_of = 2'h1;
    else if (c < ECC_B3) ecc_unit_of = 2'h2;
    else ecc_unit_of = 2'h3;
  endfunction : ecc_unit_of

  snfe_state_t   st;
  snfe_state_t   next_st;
  logic          fell;
  logic          rose_cs;
  logic          hold;
  logic          rise;
  logic          fall;
  logic          issue;
  logic          pop;
  logic          byte_done;
  logic [3:0]    nb;
  logic [7:0]    byte_in;
  logic [7:0]    cur;
  logic          buf_rdy;
  logic          buf_val;
  logic [7:0]    buf_data;
  logic [7:0]    cache_rdata;
  logic [23:0]   ra;
  snfe_mem_req_t ser_req;

  assign fell    = st.cs_n && !pin_in.cs_n;
  assign rose_cs = !st.cs_n && pin_in.cs_n;
  // The pause pin only counts when quad mode has not claimed it.
  assign hold    = !quad_enable_bit && !pin_in.io[3] && !pin_in.cs_n;
  // Only edges seen while selected count, so the idle clock level is irrelevant.
  assign rise    = pin_in.sck && !st.sck && !pin_in.cs_n && !hold;
  assign fall    = !pin_in.sck && st.sck && !pin_in.cs_n && !hold
                && st.ph == PH_DOUT;
  assign nb        = {1'b0, st.bits} + {1'b0, st.lin};
  assign byte_done = rise && nb[3];
  assign byte_in   = shift_in(st.sh, pin_in.io, st.lin);
  assign ra        = {st.addr[15:0], byte_in};
  // Fetches alternate with pushes, so the buffer never sees a push it cannot take.
  assign issue   = (st.ph == PH_DUMMY || st.ph == PH_DOUT) && !st.fpend && buf_rdy;
  assign pop     = fall && st.obits == 3'h0 && buf_val;
  // An underrun sends erased bytes rather than stale data.
  assign cur     = (st.obits != 3'h0) ? st.osh : (buf_val ? buf_data : FILL_BYTE);

  assign ser_req.we    = st.mw;
  assign ser_req.addr  = st.col;
  assign ser_req.wdata = st.mdata;

  snfe_cache #(
    .BYTES (PAGE_BYTES)
  ) u_cache (
    .core_clk   (core_clk),
    .ser_req    (ser_req),
    .ser_rdata  (cache_rdata),
    .core_req   (core_req),
    .core_rdata (core_rdata)
  );

  snfe_buf2 #(
    .W     (8),
    .DEPTH (2)
  ) u_buf (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .flush     (fell || rose_cs),
    .in_valid  (st.fpend),
    .in_data   (st.uid ? st.fbyte : cache_rdata),
    .in_ready  (buf_rdy),
    .out_valid (buf_val),
    .out_data  (buf_data),
    .out_ready (pop)
  );

  always_comb begin
    next_st        = st;
    next_st.sck    = pin_in.sck;
    next_st.cs_n   = pin_in.cs_n;
    next_st.cvalid = 1'b0;
    next_st.fpend  = issue;
    if (st.mw) begin
      next_st.mw  = 1'b0;
      next_st.col = st.col + 1'b1;
    end
    if (issue) begin
      next_st.fbyte = UNIQUE_ID[{~st.uidx, 3'b000} +: 8];
      next_st.uidx  = st.uidx + 1'b1;
      next_st.col   = wrap_next(st.col, st.wrap);
    end
    if (rise) begin
      next_st.sh   = byte_in;
      next_st.bits = nb[2:0];
    end
    if (fall) begin
      next_st.io    = drive_bits(cur, st.lout);
      next_st.oe    = lane_mask(st.lout);
      next_st.osh   = cur << st.lout;
      next_st.obits = st.obits + st.lout;
    end
    if (byte_done) begin
      next_st.nbytes = st.nbytes + 1'b1;
      case (st.ph)
        PH_CMD: begin
          next_st.op     = byte_in;
          next_st.nbytes = 3'h0;
          if (is_quad(byte_in) && !quad_enable_bit) begin
            next_st.ph = PH_SKIP;
          end else if (is_read(byte_in) || is_load(byte_in) || is_row(byte_in)) begin
            next_st.ph = PH_ADDR;
          end else if (byte_in == OP_READ_UID) begin
            next_st.ph  = PH_DUMMY;
            next_st.uid = 1'b1;
          end else begin
            next_st.ph         = PH_SKIP;
            next_st.cvalid     = 1'b1;
            next_st.cmd.opcode = byte_in;
          end
        end
        PH_ADDR: begin
          next_st.addr = ra;
          if (is_row(st.op) && st.nbytes == ROW_ADDR_BYTES - 3'h1) begin
            next_st.ph           = PH_SKIP;
            next_st.cvalid       = 1'b1;
            next_st.cmd.opcode   = st.op;
            next_st.cmd.page     = ra[PAGE_W-1:0];
            next_st.cmd.block    = ra[ROW_W-1:PAGE_W];
            next_st.cmd.column   = st.col;
            next_st.cmd.ecc_unit = ecc_unit_of(st.col);
            next_st.cmd.row_oob  = otp_mode && ra[ROW_W-1:0] >= OTP_PAGES;
          end else if (!is_row(st.op) && st.nbytes == COL_ADDR_BYTES - 3'h1) begin
            next_st.col    = ra[COL_W-1:0];
            next_st.wrap   = ra[15:12];
            next_st.oob    = ra[COL_W-1:0] > COL_LAST;
            next_st.nbytes = 3'h0;
            if (is_load(st.op)) begin
              next_st.ph  = PH_DIN;
              next_st.lin = is_quad(st.op) ? LANES_4 : LANES_1;
            end else begin
              next_st.ph = PH_DUMMY;
            end
          end
        end
        PH_DUMMY: begin
          if (st.nbytes == (st.uid ? UID_DUMMY_BYTES : DUMMY_BYTES) - 3'h1) begin
            next_st.ph = PH_DOUT;
            if (st.op == OP_READ_X4) next_st.lout = LANES_4;
            else if (st.op == OP_READ_X2) next_st.lout = LANES_2;
            else next_st.lout = LANES_1;
          end
        end
        PH_DIN: begin
          next_st.mw    = st.col <= COL_LAST;
          next_st.mdata = byte_in;
        end
        default: begin
          next_st.ph = st.ph;
        end
      endcase
    end
    if (fell) begin
      next_st.ph     = PH_CMD;
      next_st.bits   = 3'h0;
      next_st.nbytes = 3'h0;
      next_st.lin    = LANES_1;
      next_st.lout   = LANES_1;
      next_st.uid    = 1'b0;
      next_st.uidx   = 3'h0;
      next_st.obits  = 3'h0;
      next_st.oe     = 4'h0;
      next_st.addr   = '0;
    end
    // Work already passed to the array side has no abort path, so it runs on.
    if (rose_cs) begin
      next_st.ph    = PH_IDLE;
      next_st.bits  = 3'h0;
      next_st.oe    = 4'h0;
      next_st.fpend = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out.io    = st.io;
  assign pin_out.oe    = (pin_in.cs_n || hold) ? 4'h0 : st.oe;
  assign cmd_valid     = st.cvalid;
  assign cmd           = st.cmd;
  assign frame_active  = st.ph != PH_IDLE;
  assign column_oob    = st.oob;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_lines_released: assert property (
    $rose(pin_in.cs_n) |=> st.oe == 4'h0 && st.ph == PH_IDLE)
    else $error("data lines still enabled after deselect");

  a_x1_rise_sample: assert property (
    rise && st.lin == LANES_1 && st.ph == PH_CMD |=> st.sh[0] == $past(pin_in.io[0]))
    else $error("single-line bit not taken on rising edge");

  a_drive_on_fall: assert property (
    $changed(st.io) |-> $past(fall))
    else $error("output lines changed away from a falling edge");

  a_quad_gated: assert property (
    byte_done && st.ph == PH_CMD && is_quad(byte_in) && !quad_enable_bit
    |=> st.ph == PH_SKIP)
    else $error("four-line instruction accepted without quad enable");

  a_start_needs_high: assert property (
    (st.ph == PH_IDLE) ##1 (st.ph == PH_CMD) |-> $past(st.cs_n))
    else $error("frame started without a high-to-low select edge");

  a_frame_ends: assert property (
    $rose(st.cs_n) |-> st.ph == PH_IDLE && st.bits == 3'h0)
    else $error("select high did not end the frame");

  a_no_oob_write: assert property (
    ser_req.we |-> ser_req.addr <= COL_LAST)
    else $error("write to a column outside the page");

  a_wrap_16: assert property (
    issue && st.wrap == WRAP_16 && st.col[3:0] == 4'hF
    |=> st.col[3:0] == 4'h0 && st.col[COL_W-1:4] == $past(st.col[COL_W-1:4]))
    else $error("sixteen-byte wrap left its window");

  a_row_split: assert property (
    st.cvalid && is_row(st.cmd.opcode)
    |-> {st.cmd.block, st.cmd.page} == st.addr[ROW_W-1:0])
    else $error("row address split into block and page wrongly");

  a_quad_lanes: assert property (
    fall && st.lout == LANES_4 |=> st.oe == 4'hF)
    else $error("four-line read not driving all lines");

  a_dual_lanes: assert property (
    fall && st.lout == LANES_2 |=> st.oe == 4'h3 && st.io[1:0] == $past(cur[7:6]))
    else $error("two-line read not driving lines 0 and 1 msb first");

  a_pause_off_quad: assert property (
    quad_enable_bit && !pin_in.cs_n && !pin_in.io[3] |-> pin_out.oe == st.oe)
    else $error("pause cut the data lines while quad enable is set");

endmodule : snfe_top

// [tb/snfe_host.sv]
// Host model: frames, clocks and drives the serial lines in mode 0 or mode 3.
`timescale 1ns/1ps
module snfe_host (
  input  wire snfe_pkg::snfe_pin_out_t pin_out,
  input  wire logic                    core_clk,
  output snfe_pkg::snfe_pin_in_t       pin_in
);
  import snfe_pkg::*;
  logic       sck  = 1'b0;
  logic       cs_n = 1'b0;
  logic       idle = 1'b0;
  logic [3:0] drv  = 4'hF;
  logic [3:0] rel  = 4'h0;
  logic [3:0] flip = 4'h5;
  logic [3:0] lvl;
  // A released line toggles every cycle, so a stale bit can never pass for data.
  always @(posedge core_clk) flip <= ~flip;
  assign lvl = (pin_out.oe & pin_out.io) | (~pin_out.oe & ((rel & flip) | (~rel & drv)));
  assign pin_in = '{sck, cs_n, lvl};

  task automatic select(input logic m3);
    @(posedge core_clk);
    idle <= m3;
    sck  <= m3;
    cs_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    cs_n <= 1'b0;
  endtask : select

  task automatic xfer(input int n, input int ln, input logic out, input logic [31:0] v,
                      output logic [31:0] q);
    logic [31:0] sh;
    logic [3:0]  d;
    logic [3:0]  m;
    sh = v << (32 - n);
    m  = 4'((1 << ln) - 1);
    q  = '0;
    for (int j = 0; j < n / ln; j++) begin
      d = 4'hF;
      for (int l = ln - 1; l >= 0; l--) begin
        d[l] = sh[31];
        sh   = sh << 1;
      end
      @(posedge core_clk);
      sck <= 1'b0;
      drv <= d;
      rel <= out ? (ln == 1 ? 4'h2 : m) : 4'h0;
      repeat (2) @(posedge core_clk);
      sck <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      q = (q << ln) | 32'(ln == 1 ? {3'h0, lvl[1]} : lvl & m);
    end
  endtask : xfer

  task automatic deselect();
    @(posedge core_clk);
    sck <= idle;
    repeat (2) @(posedge core_clk);
    cs_n <= 1'b1;
    rel  <= 4'h0;
    repeat (4) @(posedge core_clk);
  endtask : deselect
endmodule : snfe_host

// [tb/snfe_tb_top.sv]
// Bench for the serial NAND front end: random and corner frames from a host model.
`timescale 1ns/1ps
module snfe_tb_top;
  import snfe_pkg::*;
  localparam logic [63:0] UID = 64'h0F1E_2D3C_4B5A_6978; // Arbitrary value.
  logic          core_clk;
  logic          rstn;
  logic          quad_enable_bit;
  logic          otp_mode;
  snfe_mem_req_t core_req;
  snfe_pin_in_t  pin_in;
  snfe_pin_out_t pin_out;
  logic          cmd_valid;
  snfe_cmd_t     cmd;
  snfe_cmd_t     got;
  logic          frame_active;
  logic          column_oob;
  logic [7:0]    core_rdata;
  logic [3:0]    oe_seen = 4'h0;
  logic [31:0]   seed = 32'h0000_C1C4;
  logic [31:0]   r;
  logic [31:0]   e;
  logic [7:0]    mem [int];
  int            n_cmd;
  int            fail_count;
  int            comparisons;
  int            c;
  logic [7:0] rops [6] = '{OP_PG_READ, OP_PG_EXEC, OP_ERASE, OP_LOCK, OP_UNLOCK, OP_RD_LOCK};
  logic [7:0] ropx [4] = '{OP_READ, OP_FREAD, OP_READ_X2, OP_READ_X4};
  int         lns  [4] = '{1, 1, 2, 4};
  int         sts  [4] = '{2110, 2046, 62, 30};
  int         cols [12] = '{0, 1, 16, 17, 30, 31, 62, 63, 2046, 2047, 2110, 2111};

  snfe_top #(.UNIQUE_ID(UID)) u_dut (
    .core_clk        (core_clk),
    .rstn            (rstn),
    .pin_in          (pin_in),
    .pin_out         (pin_out),
    .quad_enable_bit (quad_enable_bit),
    .otp_mode        (otp_mode),
    .cmd_valid       (cmd_valid),
    .cmd             (cmd),
    .frame_active    (frame_active),
    .column_oob      (column_oob),
    .core_req        (core_req),
    .core_rdata      (core_rdata)
  );
  snfe_host u_host (.pin_out(pin_out), .core_clk(core_clk), .pin_in(pin_in));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic int wcol(int code, int s, int k);
    int len;
    len = code == 0 ? PAGE_BYTES : code == 1 ? PAGE_MAIN : code == 2 ? 64 : 16;
    return s - s % len + (s % len + k) % len;
  endfunction : wcol

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic cwr(int a, logic [7:0] d);
    @(posedge core_clk);
    core_req <= '{1'b1, COL_W'(a), d};
    mem[a] = d;
    @(posedge core_clk);
    core_req.we <= 1'b0;
  endtask : cwr

  task automatic frame(input logic m3, input logic [7:0] op, input int an, input logic [31:0] a,
                       input int dn, input int ln, input logic out, input int nb,
                       input logic [31:0] wd, output logic [31:0] q);
    logic [31:0] t;
    u_host.select(m3);
    u_host.xfer(8, 1, 1'b0, 32'(op), t);
    if (an > 0) u_host.xfer(an, 1, 1'b0, a, t);
    if (dn > 0) u_host.xfer(dn, 1, 1'b0, 32'h0, t);
    q = '0;
    for (int i = 0; i < nb; i++) begin
      u_host.xfer(8, ln, out, wd >> (8 * (nb - 1 - i)), t);
      q = (q << 8) | (t & 32'hFF);
    end
    u_host.deselect();
  endtask : frame

  always @(posedge core_clk) begin
    oe_seen = oe_seen | pin_out.oe;
    if (cmd_valid === 1'b1) begin
      n_cmd = n_cmd + 1;
      got   = cmd;
    end
    if (pin_in.cs_n === 1'b1) check("oe_deselected", 32'(pin_out.oe), 32'h0);
  end

  initial begin
    rstn            = 1'b0;
    quad_enable_bit = 1'b0;
    otp_mode        = 1'b0;
    core_req        = '0;
    repeat (10) @(posedge core_clk);
    #1;
    check("reset_outs", 32'({pin_out.oe, frame_active, cmd_valid, column_oob}), 32'h0);
    @(posedge core_clk);
    rstn <= 1'b1;
    // Select was held low through reset, so this whole frame must be ignored.
    u_host.xfer(8, 1, 1'b0, 32'(OP_PG_READ), r);
    u_host.xfer(24, 1, 1'b0, 32'h0, r);
    check("pre_select_cmds", 32'(n_cmd), 32'h0);
    u_host.select(1'b0);
    u_host.xfer(5, 1, 1'b0, 32'h1F, r);
    u_host.deselect();
    for (int i = 0; i < 6; i++) begin
      e = rnd() & 32'h0003_FFFF;
      frame(i[0], rops[i], 24, e, 0, 1, 1'b0, 0, 32'h0, r);
      check("cmd_count", 32'(n_cmd), 32'(i + 1));
      check("cmd_opcode", 32'(got.opcode), 32'(rops[i]));
      check("cmd_block", 32'(got.block), e >> 6);
      check("cmd_page", 32'(got.page), e & 32'h3F);
    end
    foreach (cols[i]) cwr(cols[i], 8'(rnd()));
    @(posedge core_clk);
    core_req.addr <= 12'h898;
    repeat (2) @(posedge core_clk);
    #1;
    check("core_oob_read", 32'(core_rdata), 32'hFF);
    c = 100 + int'(rnd() % 1800);
    e = rnd();
    frame(1'b0, OP_LOAD, 16, 32'(c), 0, 1, 1'b0, 2, e, r);
    // Rows 7 and 8 sit on either side of the one-time area's edge.
    otp_mode <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      frame(i[0], OP_ERASE, 24, 32'(7 + i), 0, 1, 1'b0, 0, 32'h0, r);
      check("cmd_row_oob", 32'(got.row_oob), 32'(7 + i >= OTP_BYTES / PAGE_MAIN));
      check("cmd_column", 32'(got.column), 32'(c + 2));
      check("cmd_ecc_unit", 32'(got.ecc_unit), 32'((c + 2) / ECC_UNIT));
    end
    frame(1'b0, 8'h06, 0, 32'h0, 0, 1, 1'b0, 0, 32'h0, r);
    check("cmd_other", 32'(got.opcode), 32'h06);
    quad_enable_bit <= 1'b1;
    frame(1'b1, OP_LOAD_X4, 16, 32'(c + 2), 0, 4, 1'b0, 2, e >> 16, r);
    mem[c]     = e[15:8];
    mem[c + 1] = e[7:0];
    mem[c + 2] = e[31:24];
    mem[c + 3] = e[23:16];
    frame(1'b0, OP_READ, 16, 32'(c), 8, 1, 1'b1, 4, 32'h0, r);
    check("load_readback", r, {mem[c], mem[c + 1], mem[c + 2], mem[c + 3]});
    for (int o = 0; o < 4; o++) begin
      for (int w = 0; w < 4; w++) begin
        oe_seen = 4'h0;
        frame(w[0], ropx[o], 16, 32'(w * 4096 + sts[w]), 8, lns[o], 1'b1, 4, 32'h0, r);
        e = '0;
        for (int k = 0; k < 4; k++) e = (e << 8) | 32'(mem[wcol(w, sts[w], k)]);
        check("wrap_read", r, e);
        check("read_lanes", 32'(oe_seen), 32'(lns[o] == 1 ? 2 : (1 << lns[o]) - 1));
      end
    end
    quad_enable_bit <= 1'b0;
    oe_seen = 4'h0;
    frame(1'b0, OP_READ_X4, 16, 32'h0, 8, 4, 1'b1, 1, 32'h0, r);
    check("x4_refused", 32'(oe_seen), 32'h0);
    frame(1'b0, OP_LOAD_RND, 16, 32'h840, 0, 1, 1'b0, 1, 32'h5A, r);
    check("column_oob_set", 32'(column_oob), 32'h1);
    frame(1'b1, OP_READ_UID, 0, 32'h0, 32, 1, 1'b1, 4, 32'h0, r);
    check("uid_bytes", r, UID[63:32]);
    test_done();
  end

  initial begin
    #500000;
    fail_count++;
    test_done();
  end
endmodule : snfe_tb_top
